// [src/dps_frame_ctrl.sv]
// instruction counter of one engine with per-frame restart
// assumes frame_start and step are one-cycle pulses on clk
`timescale 1ns/1ns
`default_nettype none
module dps_frame_ctrl #(
    parameter int PC_W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // engine events
    input wire logic frame_start,
    input wire logic step,
    input wire logic keep_pc,
    // counter
    output logic [PC_W-1:0] pc
);

    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] pc_d;

    // ----------------------------------------
    // next count
    // ----------------------------------------
    // frame restart beats a step landing in the same cycle
    wire logic restart = frame_start && !keep_pc;
    assign pc_d = restart ? '0 : (step ? pc_q + 1'b1 : pc_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_q <= '0;
        end else begin
            pc_q <= pc_d;
        end
    end

    assign pc = pc_q;

endmodule // dps_frame_ctrl
`default_nettype wire

// [src/dps_path_decode.sv]
// turns a path select byte into engine / fixed chain choice
// assumes sel_byte comes from a register on the same clock
`timescale 1ns/1ns
`default_nettype none
module dps_path_decode
    import dps_pkg::*;
#(
    parameter bit IS_RECORD = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // select byte
    input wire logic [7:0] sel_byte,
    // decoded choice
    dps_path_if.src path
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic [4:0] code = sel_byte[SEL_MSB:0];
    wire logic [4:0] rst_code = IS_RECORD ? RST_REC_SEL[SEL_MSB:0] : RST_PLAY_SEL[SEL_MSB:0];
    wire logic code_ok = IS_RECORD ? rec_code_ok(code) : play_code_ok(code);
    wire logic rst_ok = IS_RECORD ? rec_code_ok(rst_code) : play_code_ok(rst_code);

    // reserved codes select nothing: engine off and no valid chain
    always_ff @(posedge clk) begin
        if (srst) begin
            path.use_dsp <= 1'b0;
            path.chain <= rst_code;
            path.chain_ok <= rst_ok;
        end else begin
            path.use_dsp <= (code == CODE_DSP);
            path.chain <= code;
            path.chain_ok <= code_ok;
        end
    end

endmodule // dps_path_decode
`default_nettype wire

// [src/dps_path_if.sv]
// decoded processing-path choice for one channel
// assumes one decoder drives it and the top reads it
`timescale 1ns/1ns
`default_nettype none
interface dps_path_if;
    logic use_dsp;
    logic [4:0] chain;
    logic chain_ok;
    modport src (output use_dsp, output chain, output chain_ok);
    modport dst (input use_dsp, input chain, input chain_ok);
endinterface
`default_nettype wire

// [src/dps_pkg.sv]
// constants and decode helpers for the path-select register bank
// assumes page-zero byte addressing from the serial control port decoder
package dps_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_RSVD_FIRST = 8'h37;
    localparam logic [7:0] OFS_RSVD_LAST = 8'h3B;
    localparam int RSVD_COUNT = 5;
    localparam logic [7:0] OFS_PLAY_SEL = 8'h3C;
    localparam logic [7:0] OFS_REC_SEL = 8'h3D;
    localparam logic [7:0] OFS_MODE = 8'h3E;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_PLAY_SEL = 8'h01;
    localparam logic [7:0] RST_REC_SEL = 8'h04;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_RSVD = 8'h00;

    // ----------------------------------------
    // fields
    // ----------------------------------------
    localparam int SEL_MSB = 4;
    localparam int SEL_W = 5;
    localparam int REC_AUX_A = 6;
    localparam int REC_AUX_B = 5;
    localparam int REC_KEEP_PC = 4;
    localparam int PLAY_AUX_A = 2;
    localparam int PLAY_AUX_B = 1;
    localparam int PLAY_KEEP_PC = 0;

    // ----------------------------------------
    // path select codes
    // ----------------------------------------
    localparam logic [4:0] CODE_DSP = 5'h00;
    localparam logic [4:0] PLAY_LO_A = 5'h04;
    localparam logic [4:0] PLAY_HI_A = 5'h06;
    localparam logic [4:0] PLAY_LO_B = 5'h0C;
    localparam logic [4:0] PLAY_HI_B = 5'h10;
    localparam logic [4:0] PLAY_ONE = 5'h14;
    localparam logic [4:0] REC_LO_A = 5'h04;
    localparam logic [4:0] REC_HI_A = 5'h06;
    localparam logic [4:0] REC_LO_B = 5'h0A;
    localparam logic [4:0] REC_HI_B = 5'h0C;
    localparam logic [4:0] REC_LO_C = 5'h10;
    localparam logic [4:0] REC_HI_C = 5'h12;

    function automatic logic play_code_ok(input logic [4:0] c);
        return (c >= PLAY_LO_A && c <= PLAY_HI_A) ||
            (c >= PLAY_LO_B && c <= PLAY_HI_B) || (c == PLAY_ONE);
    endfunction

    function automatic logic rec_code_ok(input logic [4:0] c);
        return (c >= REC_LO_A && c <= REC_HI_A) ||
            (c >= REC_LO_B && c <= REC_HI_B) || (c >= REC_LO_C && c <= REC_HI_C);
    endfunction

endpackage

// [src/dps_regs.sv]
// path-select and engine mode register bank, page zero 0x37..0x3E
// assumes a serial control port decoder giving byte writes and reads
// on clk, and engine frame / step pulses on the same clock
`timescale 1ns/1ns
`default_nettype none

module dps_regs
    import dps_pkg::*;
#(
    parameter int PC_W = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register port from the control interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    // playback engine side
    input wire logic play_frame_start,
    input wire logic play_step,
    output logic play_use_dsp,
    output logic [4:0] play_chain,
    output logic play_chain_valid,
    output logic play_cond_a,
    output logic play_cond_b,
    output logic [PC_W-1:0] play_pc,
    // record engine side
    input wire logic rec_frame_start,
    input wire logic rec_step,
    output logic rec_use_dsp,
    output logic [4:0] rec_chain,
    output logic rec_chain_valid,
    output logic rec_cond_a,
    output logic rec_cond_b,
    output logic [PC_W-1:0] rec_pc
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0] play_sel_q;
    logic [7:0] rec_sel_q;
    logic [7:0] mode_q;
    logic [7:0] rsvd_q [RSVD_COUNT];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire logic hit_play = (reg_addr == OFS_PLAY_SEL);
    wire logic hit_rec = (reg_addr == OFS_REC_SEL);
    wire logic hit_mode = (reg_addr == OFS_MODE);
    wire logic hit_rsvd = (reg_addr >= OFS_RSVD_FIRST) && (reg_addr <= OFS_RSVD_LAST);
    wire logic [ADDR_W-1:0] rsvd_ofs = reg_addr - OFS_RSVD_FIRST;
    wire logic [2:0] rsvd_idx = rsvd_ofs[2:0];
    wire logic wr_play = reg_wr && hit_play;
    wire logic wr_rec = reg_wr && hit_rec;
    wire logic wr_mode = reg_wr && hit_mode;
    wire logic wr_rsvd = reg_wr && hit_rsvd;

    // ----------------------------------------
    // writable registers
    // ----------------------------------------
    // all eight bits are kept, including the bits the host must
    // hold at zero, so readback shows exactly what was written
    always_ff @(posedge clk) begin
        if (srst) begin
            play_sel_q <= RST_PLAY_SEL;
            rec_sel_q <= RST_REC_SEL;
            mode_q <= RST_MODE;
        end else begin
            if (wr_play) begin
                play_sel_q <= reg_wdata;
            end
            if (wr_rec) begin
                rec_sel_q <= reg_wdata;
            end
            if (wr_mode) begin
                mode_q <= reg_wdata;
            end
        end
    end

    // reserved locations behave as plain storage; the host is not
    // meant to touch them, so nothing downstream reads them
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < RSVD_COUNT; i++) begin
                rsvd_q[i] <= RST_RSVD;
            end
        end else if (wr_rsvd) begin
            rsvd_q[rsvd_idx] <= reg_wdata;
        end
    end

    // ----------------------------------------
    // readback
    // ----------------------------------------
    assign rdata_d = hit_play ? play_sel_q :
        hit_rec ? rec_sel_q :
        hit_mode ? mode_q :
        hit_rsvd ? rsvd_q[rsvd_idx] : UNMAPPED_DATA;

    // data holds between reads
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= UNMAPPED_DATA;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // path decode
    // ----------------------------------------
    dps_path_if play_path ();
    dps_path_if rec_path ();

    dps_path_decode #(
        .IS_RECORD(1'b0)
    ) u_play_dec (
        .clk(clk),
        .srst(srst),
        .sel_byte(play_sel_q),
        .path(play_path.src)
    );

    dps_path_decode #(
        .IS_RECORD(1'b1)
    ) u_rec_dec (
        .clk(clk),
        .srst(srst),
        .sel_byte(rec_sel_q),
        .path(rec_path.src)
    );

    assign play_use_dsp = play_path.use_dsp;
    assign play_chain = play_path.chain;
    assign play_chain_valid = play_path.chain_ok;
    assign rec_use_dsp = rec_path.use_dsp;
    assign rec_chain = rec_path.chain;
    assign rec_chain_valid = rec_path.chain_ok;

    // ----------------------------------------
    // engine conditions
    // ----------------------------------------
    assign rec_cond_a = mode_q[REC_AUX_A];
    assign rec_cond_b = mode_q[REC_AUX_B];
    assign play_cond_a = mode_q[PLAY_AUX_A];
    assign play_cond_b = mode_q[PLAY_AUX_B];

    // ----------------------------------------
    // instruction counters
    // ----------------------------------------
    dps_frame_ctrl #(
        .PC_W(PC_W)
    ) u_play_pc (
        .clk(clk),
        .srst(srst),
        .frame_start(play_frame_start),
        .step(play_step),
        .keep_pc(mode_q[PLAY_KEEP_PC]),
        .pc(play_pc)
    );

    dps_frame_ctrl #(
        .PC_W(PC_W)
    ) u_rec_pc (
        .clk(clk),
        .srst(srst),
        .frame_start(rec_frame_start),
        .step(rec_step),
        .keep_pc(mode_q[REC_KEEP_PC]),
        .pc(rec_pc)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_play_write(logic [4:0] c);
        wr_play && reg_wdata[SEL_MSB:0] == c;
    endsequence

    sequence s_rec_write(logic [4:0] c);
        wr_rec && reg_wdata[SEL_MSB:0] == c;
    endsequence

    // a write reaches the decoded outputs two edges later
    play_engine_sel_a: assert property (
        s_play_write(CODE_DSP) |-> ##2 play_use_dsp && !play_chain_valid)
        else $error("playback engine not selected by code zero");

    play_chain_sel_a: assert property (
        wr_play && play_code_ok(reg_wdata[SEL_MSB:0])
        |-> ##2 play_chain_valid && !play_use_dsp
            && play_chain == $past(reg_wdata[SEL_MSB:0], 2))
        else $error("playback chain code not decoded");

    // reset is the only way in to a reserved playback code, the host never writes one
    play_rsvd_code_a: assert property (
        !play_code_ok(play_sel_q[SEL_MSB:0]) && play_sel_q[SEL_MSB:0] != CODE_DSP
        |=> !play_chain_valid && !play_use_dsp)
        else $error("reserved playback code gave a path");

    rec_engine_sel_a: assert property (
        s_rec_write(CODE_DSP) |-> ##2 rec_use_dsp && !rec_chain_valid)
        else $error("record engine not selected by code zero");

    rec_chain_sel_a: assert property (
        wr_rec && rec_code_ok(reg_wdata[SEL_MSB:0])
        |-> ##2 rec_chain_valid && !rec_use_dsp
            && rec_chain == $past(reg_wdata[SEL_MSB:0], 2))
        else $error("record chain code not decoded");

    rec_rsvd_code_a: assert property (
        s_rec_write(5'h13) |-> ##2 !rec_chain_valid && !rec_use_dsp)
        else $error("reserved record code gave a path");

    rec_cond_bits_a: assert property (
        wr_mode |=> rec_cond_a == $past(reg_wdata[REC_AUX_A])
            && rec_cond_b == $past(reg_wdata[REC_AUX_B]))
        else $error("record conditions do not follow mode write");

    play_cond_bits_a: assert property (
        wr_mode |=> play_cond_a == $past(reg_wdata[PLAY_AUX_A])
            && play_cond_b == $past(reg_wdata[PLAY_AUX_B]))
        else $error("playback conditions do not follow mode write");

    rec_pc_restart_a: assert property (
        rec_frame_start && !mode_q[REC_KEEP_PC] |=> rec_pc == '0)
        else $error("record counter not restarted at frame");

    rec_pc_keep_a: assert property (
        rec_frame_start && mode_q[REC_KEEP_PC] && !rec_step |=> $stable(rec_pc))
        else $error("record counter disturbed across frame");

    play_pc_restart_a: assert property (
        play_frame_start && !mode_q[PLAY_KEEP_PC] |=> play_pc == '0)
        else $error("playback counter not restarted at frame");

    play_pc_keep_a: assert property (
        play_frame_start && mode_q[PLAY_KEEP_PC] && play_step
        |=> play_pc == $past(play_pc) + 1'b1)
        else $error("playback counter did not run across frame");

    reset_values_a: assert property (
        $fell(srst) |-> play_sel_q == RST_PLAY_SEL && rec_sel_q == RST_REC_SEL
            && mode_q == RST_MODE && rec_chain == REC_LO_A && rec_chain_valid)
        else $error("register not at reset value after release");

    readback_a: assert property (
        reg_rd && hit_mode |=> reg_rdata == $past(mode_q))
        else $error("read did not return last written value");

    unmapped_read_a: assert property (
        reg_rd && !(hit_play || hit_rec || hit_mode || hit_rsvd)
        |=> reg_rdata == UNMAPPED_DATA)
        else $error("unmapped read not zero");

    play_sel_store_a: assert property (
        wr_play |=> play_sel_q == $past(reg_wdata))
        else $error("playback select write not stored");

    rec_sel_store_a: assert property (
        wr_rec |=> rec_sel_q == $past(reg_wdata))
        else $error("record select write not stored");

    play_pc_hold_a: assert property (
        !play_frame_start && !play_step |=> $stable(play_pc))
        else $error("playback counter moved without an event");

    rec_pc_hold_a: assert property (
        !rec_frame_start && !rec_step |=> $stable(rec_pc))
        else $error("record counter moved without an event");

    rec_pc_step_a: assert property (
        !rec_frame_start && rec_step |=> rec_pc == $past(rec_pc) + 1'b1)
        else $error("record counter did not advance on a step");

endmodule // dps_regs
`default_nettype wire

// [tb/dps_host_model.sv]
// host-side model: issues byte writes and reads on the register port
// assumes the bench calls wr / rd hierarchically, one access at a time
`timescale 1ns/1ns
`default_nettype none
module dps_host_model
    import dps_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // ----------------------------------------
    // accesses
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a >= OFS_RSVD_FIRST && a <= OFS_RSVD_LAST) return;
        @(negedge clk);
        reg_addr = a;
        reg_wdata = (a == OFS_PLAY_SEL || a == OFS_REC_SEL) ? {3'h0, d[4:0]} : d;
        reg_wr = 1'b1;
        @(posedge clk);
        @(negedge clk);
        reg_wr = 1'b0;
        // released data must not look like a held value
        reg_wdata = ~reg_wdata;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule // dps_host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the path-select register bank
// assumes the host model owns the register port, the bench the engine pulses
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dps_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic play_frame_start = 1'b0, play_step = 1'b0, rec_frame_start = 1'b0, rec_step = 1'b0;
    logic play_use_dsp, play_chain_valid, play_cond_a, play_cond_b;
    logic rec_use_dsp, rec_chain_valid, rec_cond_a, rec_cond_b;
    logic [4:0] play_chain, rec_chain;
    logic [9:0] play_pc, rec_pc;
    int err_count = 0, checked = 0, cycles = 0;
    // legal codes only: host never sends reserved codes
    localparam logic [4:0] PCODE [10] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h0C, 5'h0D,
        5'h0E, 5'h0F, 5'h10, 5'h14};
    localparam logic [4:0] RCODE [10] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h0A, 5'h0B,
        5'h0C, 5'h10, 5'h11, 5'h12};

    dps_regs i_dps_regs (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .play_frame_start(play_frame_start), .play_step(play_step),
        .play_use_dsp(play_use_dsp), .play_chain(play_chain),
        .play_chain_valid(play_chain_valid), .play_cond_a(play_cond_a),
        .play_cond_b(play_cond_b), .play_pc(play_pc),
        .rec_frame_start(rec_frame_start), .rec_step(rec_step), .rec_use_dsp(rec_use_dsp),
        .rec_chain(rec_chain), .rec_chain_valid(rec_chain_valid), .rec_cond_a(rec_cond_a),
        .rec_cond_b(rec_cond_b), .rec_pc(rec_pc));
    dps_host_model i_dps_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    always #5 clk = ~clk;

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic finish_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk_out(input string n, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        i_dps_host_model.rd(a, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD reg %h exp %h got %h", a, e, g);
        end
    endtask

    // ev: the code names a fixed chain; reserved codes and code zero do not
    task automatic chk_path(input logic [4:0] c, input logic ev, input logic u,
        input logic [4:0] ch, input logic v);
        chk_out("use_dsp", {9'h0, c == 5'h00}, {9'h0, u});
        chk_out("chain", {5'h00, c}, {5'h00, ch});
        chk_out("chain_valid", {9'h0, ev}, {9'h0, v});
    endtask

    task automatic pulse(input logic fs, input logic st, input int n);
        play_frame_start = fs;
        rec_frame_start = fs;
        play_step = st;
        rec_step = st;
        repeat (n) @(negedge clk);
        play_frame_start = 1'b0;
        rec_frame_start = 1'b0;
        play_step = 1'b0;
        rec_step = 1'b0;
        // idle cycle so a following call never redrives these in one step
        @(negedge clk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk_rd(OFS_PLAY_SEL, 8'h01);
        chk_rd(OFS_REC_SEL, 8'h04);
        chk_rd(OFS_MODE, 8'h00);
        chk_path(5'h01, 1'b0, play_use_dsp, play_chain, play_chain_valid);
        chk_path(5'h04, 1'b1, rec_use_dsp, rec_chain, rec_chain_valid);
        i_dps_host_model.wr(8'h50, 8'hA5);
        chk_rd(8'h50, 8'h00);
        for (int i = 0; i < 10; i++) begin
            i_dps_host_model.wr(OFS_PLAY_SEL, {3'h0, PCODE[i]});
            i_dps_host_model.wr(OFS_REC_SEL, {3'h0, RCODE[i]});
            repeat (2) @(negedge clk);
            chk_path(PCODE[i], PCODE[i] != 5'h00, play_use_dsp, play_chain,
                play_chain_valid);
            chk_path(RCODE[i], RCODE[i] != 5'h00, rec_use_dsp, rec_chain,
                rec_chain_valid);
            chk_rd(OFS_PLAY_SEL, {3'h0, PCODE[i]});
        end
        for (int i = 0; i < 8; i++) begin
            i_dps_host_model.wr(OFS_MODE, 8'h01 << i);
            repeat (2) @(negedge clk);
            chk_out("rec_cond", {8'h00, i == 6, i == 5},
                {8'h00, rec_cond_a, rec_cond_b});
            chk_out("play_cond", {8'h00, i == 2, i == 1},
                {8'h00, play_cond_a, play_cond_b});
            chk_rd(OFS_MODE, 8'h01 << i);
        end
        i_dps_host_model.wr(OFS_MODE, 8'h00);
        pulse(1'b1, 1'b0, 1);
        pulse(1'b0, 1'b1, 3);
        chk_out("play_pc", 10'h003, play_pc);
        pulse(1'b1, 1'b1, 1);
        chk_out("play_pc", 10'h000, play_pc);
        chk_out("rec_pc", 10'h000, rec_pc);
        i_dps_host_model.wr(OFS_MODE, 8'h11);
        pulse(1'b1, 1'b1, 2);
        chk_out("play_pc", 10'h002, play_pc);
        chk_out("rec_pc", 10'h002, rec_pc);
        i_dps_host_model.wr(OFS_MODE, 8'h10);
        pulse(1'b1, 1'b0, 1);
        chk_out("play_pc", 10'h000, play_pc);
        chk_out("rec_pc", 10'h002, rec_pc);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk_rd(OFS_PLAY_SEL, 8'h01);
        chk_rd(OFS_REC_SEL, 8'h04);
        chk_rd(OFS_MODE, 8'h00);
        chk_out("rec_pc", 10'h000, rec_pc);
        chk_out("play_pc", 10'h000, play_pc);
        finish_test();
    end
endmodule // tb
`default_nettype wire
